// file: rtl/pdbt_defs.svh
// register offsets, field positions, reset values for the bias and gain bank
`ifndef PDBT_DEFS_SVH
`define PDBT_DEFS_SVH

`define PDBT_ADDR_CATH 8'h54
`define PDBT_ADDR_GAIN 8'h55
`define PDBT_RST_CATH 16'h0020
`define PDBT_RST_GAIN 16'h0000

`define PDBT_OVR_BIT 7
`define PDBT_SLEEP_LSB 12
`define PDBT_SLOTB_CATH_LSB 10
`define PDBT_SLOTA_CATH_LSB 8

`define PDBT_B_CH4_LSB 10
`define PDBT_B_CH3_LSB 8
`define PDBT_B_CH2_LSB 6
`define PDBT_A_CH4_LSB 4

`endif

// file: rtl/pdbt_pkg.sv
// types shared by the bias and gain configuration bank
package pdbt_pkg;

    typedef enum logic [2:0] {
        PDBT_CATH_VDD,
        PDBT_CATH_ANODE,
        PDBT_CATH_REV250,
        PDBT_CATH_GND,
        PDBT_CATH_VREF,
        PDBT_CATH_FLOAT,
        PDBT_CATH_GLB_1V3,
        PDBT_CATH_GLB_1V8
    } pdbt_cath_t;

    typedef enum logic [1:0] {
        PDBT_PH_IDLE,
        PDBT_PH_SLEEP,
        PDBT_PH_SLOT_A,
        PDBT_PH_SLOT_B
    } pdbt_phase_t;

    typedef struct packed {
        logic [15:0] cathode_bias_select;
        logic [15:0] channel_gain_select;
        logic [15:0] rdata;
        logic rvalid;
        pdbt_phase_t phase;
        pdbt_cath_t cath;
        logic [1:0] anode;
    } pdbt_state_t;

    typedef struct packed {
        logic [1:0] code;
        logic active;
    } pdbt_lane_t;

    function automatic logic [1:0] pdbt_field(input logic [15:0] word, input int lsb);
        pdbt_field = word[lsb +: 2];
    endfunction : pdbt_field

endpackage : pdbt_pkg

// file: rtl/pdbt_gain_lane.sv
// one channel gain lane: code is applied only while its slot gain enable is set
`timescale 1ns/1ns
`default_nettype none
module pdbt_gain_lane
    import pdbt_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_gain_en,
    input wire logic [1:0] i_code,
    output logic [1:0] o_code,
    output logic o_active
);
    pdbt_lane_t st_ff;
    pdbt_lane_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        // disabled lane falls back to code 0, highest gain
        nxt_st.active = i_gain_en;
        nxt_st.code = i_gain_en ? i_code : 2'h0;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_code = st_ff.code;
    assign o_active = st_ff.active;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    lane_gated_a: assert property (!i_gain_en |=> (o_code == 2'h0) && !o_active)
        else $error("gain code applied while lane disabled");
    lane_follow_a: assert property (i_gain_en |=> o_active && (o_code == $past(i_code)))
        else $error("enabled lane does not follow its code");
endmodule : pdbt_gain_lane
`default_nettype wire

// file: rtl/pdbt_bias_gain.sv
// cathode bias selection and channel gain configuration registers
`timescale 1ns/1ns
`default_nettype none
`include "pdbt_defs.svh"
// Functional notes
// - override bit 7 clear uses global cathode bit; set uses per-state fields.
// - override set, sleep field [13:12] applies asleep; 1 gives reference in idle.
// - override set, field [11:10] drives cathode during slot B.
// - override set, field [9:8] drives cathode during slot A.
// - slot codes: 0 supply, 1 anode, 2 reverse bias about 250 mV, 3 ground.
// - anode bias per slot comes from that slot's mode bits [5:4].
// - slot B channel 4 gain [11:10] used only with slot B gain enable.
// - slot B channel 3 gain [9:8] used only with slot B gain enable.
// - slot B channel 2 gain [7:6] used only with slot B gain enable.
// - slot A channel 4 gain [5:4] used only with slot A gain enable.
// - global bit 0 gives 1.3 V equal to anode, 1 gives 1.8 V.
module pdbt_bias_gain
    import pdbt_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    output logic [15:0] o_reg_rdata,
    output logic o_reg_rvalid,
    input wire logic i_sleep,
    input wire logic i_slot_a_active,
    input wire logic i_slot_b_active,
    input wire logic i_global_cathode,
    input wire logic i_first_slot_gain_en,
    input wire logic i_second_slot_gain_en,
    input wire logic [1:0] i_first_slot_anode_bias,
    input wire logic [1:0] i_second_slot_anode_bias,
    output logic [2:0] o_cathode_sel,
    output logic [1:0] o_anode_bias,
    output logic [1:0] o_phase,
    output logic [1:0] o_second_slot_ch4_gain,
    output logic o_second_slot_ch4_active,
    output logic [1:0] o_second_slot_ch3_gain,
    output logic o_second_slot_ch3_active,
    output logic [1:0] o_second_slot_ch2_gain,
    output logic o_second_slot_ch2_active,
    output logic [1:0] o_first_slot_ch4_gain,
    output logic o_first_slot_ch4_active
);
    pdbt_state_t st_ff;
    pdbt_state_t nxt_st;
    pdbt_phase_t phase_now;
    logic cathode_override_en;
    logic [1:0] sleep_cathode_sel;
    logic [1:0] second_slot_cathode_sel;
    logic [1:0] first_slot_cathode_sel;

    assign cathode_override_en = st_ff.cathode_bias_select[`PDBT_OVR_BIT];
    assign sleep_cathode_sel = pdbt_field(st_ff.cathode_bias_select, `PDBT_SLEEP_LSB);
    assign second_slot_cathode_sel = pdbt_field(st_ff.cathode_bias_select, `PDBT_SLOTB_CATH_LSB);
    assign first_slot_cathode_sel = pdbt_field(st_ff.cathode_bias_select, `PDBT_SLOTA_CATH_LSB);

    // slot activity outranks sleep so a late sleep request cannot starve a slot
    always_comb begin
        if (i_slot_a_active) begin
            phase_now = PDBT_PH_SLOT_A;
        end else if (i_slot_b_active) begin
            phase_now = PDBT_PH_SLOT_B;
        end else if (i_sleep) begin
            phase_now = PDBT_PH_SLEEP;
        end else begin
            phase_now = PDBT_PH_IDLE;
        end
    end

    function automatic pdbt_cath_t slot_decode(input logic [1:0] code);
        case (code)
            2'h0: slot_decode = PDBT_CATH_VDD;
            2'h1: slot_decode = PDBT_CATH_ANODE;
            2'h2: slot_decode = PDBT_CATH_REV250;
            default: slot_decode = PDBT_CATH_GND;
        endcase
    endfunction : slot_decode

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rvalid = 1'b0;
        nxt_st.phase = phase_now;
        if (i_reg_wr) begin
            // reserved bits are stored as written; keeping them clean is software's job
            if (i_reg_addr == `PDBT_ADDR_CATH) begin
                nxt_st.cathode_bias_select = i_reg_wdata;
            end
            if (i_reg_addr == `PDBT_ADDR_GAIN) begin
                nxt_st.channel_gain_select = i_reg_wdata;
            end
        end
        if (i_reg_rd) begin
            nxt_st.rvalid = 1'b1;
            if (i_reg_addr == `PDBT_ADDR_CATH) begin
                nxt_st.rdata = st_ff.cathode_bias_select;
            end else if (i_reg_addr == `PDBT_ADDR_GAIN) begin
                nxt_st.rdata = st_ff.channel_gain_select;
            end else begin
                nxt_st.rdata = 16'h0000;
            end
        end
        if (!cathode_override_en) begin
            nxt_st.cath = i_global_cathode ? PDBT_CATH_GLB_1V8 : PDBT_CATH_GLB_1V3;
        end else begin
            case (phase_now)
                PDBT_PH_SLOT_A: nxt_st.cath = slot_decode(first_slot_cathode_sel);
                PDBT_PH_SLOT_B: nxt_st.cath = slot_decode(second_slot_cathode_sel);
                PDBT_PH_SLEEP, PDBT_PH_IDLE: begin
                    case (sleep_cathode_sel)
                        2'h0: nxt_st.cath = PDBT_CATH_VDD;
                        2'h1: nxt_st.cath = (phase_now == PDBT_PH_IDLE) ? PDBT_CATH_VREF : PDBT_CATH_VDD;
                        2'h2: nxt_st.cath = PDBT_CATH_FLOAT;
                        default: nxt_st.cath = PDBT_CATH_GND;
                    endcase
                end
                default: nxt_st.cath = PDBT_CATH_VDD;
            endcase
        end
        // anode bias does not depend on the cathode fields
        case (phase_now)
            PDBT_PH_SLOT_A: nxt_st.anode = i_first_slot_anode_bias;
            PDBT_PH_SLOT_B: nxt_st.anode = i_second_slot_anode_bias;
            default: nxt_st.anode = st_ff.anode;
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_ff <= '{cathode_bias_select: `PDBT_RST_CATH, channel_gain_select: `PDBT_RST_GAIN,
                       rdata: 16'h0000, rvalid: 1'b0, phase: PDBT_PH_IDLE,
                       cath: PDBT_CATH_GLB_1V3, anode: 2'h0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_reg_rdata = st_ff.rdata;
    assign o_reg_rvalid = st_ff.rvalid;
    assign o_cathode_sel = st_ff.cath;
    assign o_anode_bias = st_ff.anode;
    assign o_phase = st_ff.phase;

    pdbt_gain_lane u_b_ch4 (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_gain_en(i_second_slot_gain_en),
        .i_code(pdbt_field(st_ff.channel_gain_select, `PDBT_B_CH4_LSB)),
        .o_code(o_second_slot_ch4_gain),
        .o_active(o_second_slot_ch4_active)
    );
    pdbt_gain_lane u_b_ch3 (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_gain_en(i_second_slot_gain_en),
        .i_code(pdbt_field(st_ff.channel_gain_select, `PDBT_B_CH3_LSB)),
        .o_code(o_second_slot_ch3_gain),
        .o_active(o_second_slot_ch3_active)
    );
    pdbt_gain_lane u_b_ch2 (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_gain_en(i_second_slot_gain_en),
        .i_code(pdbt_field(st_ff.channel_gain_select, `PDBT_B_CH2_LSB)),
        .o_code(o_second_slot_ch2_gain),
        .o_active(o_second_slot_ch2_active)
    );
    pdbt_gain_lane u_a_ch4 (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_gain_en(i_first_slot_gain_en),
        .i_code(pdbt_field(st_ff.channel_gain_select, `PDBT_A_CH4_LSB)),
        .o_code(o_first_slot_ch4_gain),
        .o_active(o_first_slot_ch4_active)
    );

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence seq_ovr_off;
        !cathode_override_en;
    endsequence
    sequence seq_ovr_slot_a;
        cathode_override_en && i_slot_a_active;
    endsequence
    sequence seq_ovr_sleep;
        cathode_override_en && !i_slot_a_active && !i_slot_b_active && i_sleep;
    endsequence

    global_cathode_a: assert property (seq_ovr_off |=> o_cathode_sel inside {PDBT_CATH_GLB_1V3, PDBT_CATH_GLB_1V8})
        else $error("global cathode not used with override clear");
    global_level_a: assert property (seq_ovr_off ##0 i_global_cathode |=> o_cathode_sel == PDBT_CATH_GLB_1V8)
        else $error("global bit 1 did not give 1.8 V");
    sleep_float_a: assert property (seq_ovr_sleep ##0 sleep_cathode_sel == 2'h2
        |=> o_cathode_sel == PDBT_CATH_FLOAT)
        else $error("sleep float code not applied");
    sleep_vdd_a: assert property (seq_ovr_sleep ##0 sleep_cathode_sel == 2'h1
        |=> o_cathode_sel == PDBT_CATH_VDD)
        else $error("sleep supply code not applied");
    idle_vref_a: assert property (cathode_override_en && !i_slot_a_active && !i_slot_b_active && !i_sleep
        && sleep_cathode_sel == 2'h1 |=> o_cathode_sel == PDBT_CATH_VREF)
        else $error("idle reference not applied");
    slot_b_cath_a: assert property (cathode_override_en && !i_slot_a_active && i_slot_b_active
        && second_slot_cathode_sel == 2'h2 |=> o_cathode_sel == PDBT_CATH_REV250)
        else $error("slot B cathode field not applied");
    slot_a_cath_a: assert property (seq_ovr_slot_a ##0 first_slot_cathode_sel == 2'h3
        |=> o_cathode_sel == PDBT_CATH_GND)
        else $error("slot A cathode field not applied");
    anode_slot_a_a: assert property (i_slot_a_active |=> o_anode_bias == $past(i_first_slot_anode_bias))
        else $error("slot A anode bias wrong");
    anode_slot_b_a: assert property (!i_slot_a_active && i_slot_b_active
        |=> o_anode_bias == $past(i_second_slot_anode_bias))
        else $error("slot B anode bias wrong");
    write_read_a: assert property (i_reg_wr && i_reg_addr == `PDBT_ADDR_GAIN ##1 i_reg_rd
        && i_reg_addr == `PDBT_ADDR_GAIN && !i_reg_wr |=> o_reg_rvalid && o_reg_rdata == $past(i_reg_wdata, 2))
        else $error("gain register readback wrong");
    read_pulse_a: assert property (o_reg_rvalid == $past(i_reg_rd))
        else $error("read valid is not a one cycle answer");
    unmapped_read_a: assert property (i_reg_rd && i_reg_addr != `PDBT_ADDR_CATH && i_reg_addr != `PDBT_ADDR_GAIN
        |=> o_reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    gain_gate_a: assert property (!i_second_slot_gain_en |=> o_second_slot_ch4_gain == 2'h0)
        else $error("slot B channel 4 gain used while disabled");
endmodule : pdbt_bias_gain
`default_nettype wire

// file: verification/pdbt_host_model.sv
// host side model: drives the register port of the bias and gain bank
`timescale 1ns/1ns
`default_nettype none
module pdbt_host_model (
    input wire logic i_clk,
    input wire logic i_rvalid,
    input wire logic [15:0] i_rdata,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_addr,
    output logic [15:0] o_wdata
);
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 8'h00;
        o_wdata = 16'h0000;
    end

    // reserved top bits zero, low seven bits kept at their default
    function automatic logic [15:0] cath_word(input logic ovr, input logic [1:0] slp, input logic [1:0] sb,
                                              input logic [1:0] sa);
        cath_word = {2'b00, slp, sb, sa, ovr, 7'h20};
    endfunction : cath_word

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge i_clk);
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(negedge i_clk);
        o_wr = 1'b0;
    endtask : wr

    // read follows the write in the very next cycle, so the new word must already be visible
    task automatic wr_rd(input logic [7:0] a, input logic [15:0] d, output logic [15:0] q, output logic ok);
        @(negedge i_clk);
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(negedge i_clk);
        o_wr = 1'b0;
        o_rd = 1'b1;
        @(negedge i_clk);
        o_rd = 1'b0;
        ok = (i_rvalid === 1'b1);
        q = i_rdata;
    endtask : wr_rd

    // bounded wait so a missing answer cannot hang the host
    task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
        @(negedge i_clk);
        o_addr = a;
        o_rd = 1'b1;
        ok = 1'b0;
        d = 16'h0000;
        for (int n = 0; n < 4 && !ok; n++) begin
            @(negedge i_clk);
            o_rd = 1'b0;
            if (i_rvalid === 1'b1) begin
                ok = 1'b1;
                d = i_rdata;
            end
        end
    endtask : rd
endmodule : pdbt_host_model
`default_nettype wire

// file: verification/pdbt_bias_gain_tb.sv
// self-checking bench for the bias and gain configuration bank
`timescale 1ns/1ns
`default_nettype none
module pdbt_bias_gain_tb;
    import pdbt_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst, wr, rd, rvalid, slp, sa, sb, glb, en_a, en_b, ok;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, rv;
    logic [2:0] cath;
    logic [1:0] anode, k, g_b4, g_b3, g_b2, g_a4, an_a, an_b, phs;
    logic act_b4, act_b3, act_b2, act_a4;
    logic [2:0] slp_exp [4] = '{3'h0, 3'h0, 3'h5, 3'h3};
    int fails = 0;
    int checks_done = 0;

    always #20 i_clk = ~i_clk;

    pdbt_bias_gain pdbt_bias_gain_inst (.i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_sleep(slp),
        .i_slot_a_active(sa), .i_slot_b_active(sb), .i_global_cathode(glb), .i_first_slot_gain_en(en_a),
        .i_second_slot_gain_en(en_b), .i_first_slot_anode_bias(an_a), .i_second_slot_anode_bias(an_b),
        .o_cathode_sel(cath), .o_anode_bias(anode), .o_phase(phs), .o_second_slot_ch4_gain(g_b4),
        .o_second_slot_ch4_active(act_b4), .o_second_slot_ch3_gain(g_b3), .o_second_slot_ch3_active(act_b3),
        .o_second_slot_ch2_gain(g_b2), .o_second_slot_ch2_active(act_b2), .o_first_slot_ch4_gain(g_a4),
        .o_first_slot_ch4_active(act_a4));
    pdbt_host_model pdbt_host_model_inst (.i_clk(i_clk), .i_rvalid(rvalid), .i_rdata(rdata), .o_wr(wr),
        .o_rd(rd), .o_addr(addr), .o_wdata(wdata));

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [15:0] exp);
        pdbt_host_model_inst.rd(a, rv, ok);
        chk("read valid", 16'(ok), 16'h0001);
        chk(nm, rv, exp);
    endtask : rdchk

    // outputs lag a register write by two edges, so three cycles is safe
    task automatic settle();
        repeat (3) @(negedge i_clk);
    endtask : settle

    task automatic ph(input logic s, input logic a, input logic b);
        slp = s;
        sa = a;
        sb = b;
    endtask : ph

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    initial begin
        #200000;
        fails++;
        print_verdict();
    end

    initial begin
        i_rst = 1'b1;
        ph(1'b0, 1'b0, 1'b0);
        glb = 1'b0;
        en_a = 1'b0;
        en_b = 1'b0;
        an_a = 2'h0;
        an_b = 2'h0;
        repeat (2) @(negedge i_clk);
        i_rst = 1'b0;
        rdchk("cathode reg reset", 8'h54, 16'h0020);
        rdchk("gain reg reset", 8'h55, 16'h0000);
        rdchk("unmapped read", 8'h56, 16'h0000);
        $display("test reset values done");
        // slot field set but override clear: it must be ignored
        pdbt_host_model_inst.wr(8'h54, pdbt_host_model_inst.cath_word(1'b0, 2'h3, 2'h3, 2'h3));
        ph(1'b0, 1'b1, 1'b0);
        for (int g = 0; g < 2; g++) begin
            glb = g[0];
            settle();
            chk("global cathode", 16'(cath), 16'(6 + g));
        end
        $display("test global cathode done");
        for (int c = 0; c < 4; c++) begin
            k = c[1:0];
            pdbt_host_model_inst.wr(8'h54, pdbt_host_model_inst.cath_word(1'b1, k + 2'h1, ~k, k));
            an_a = k;
            an_b = ~k;
            ph(1'b0, 1'b1, 1'b0);
            settle();
            chk("slot a cathode", 16'(cath), 16'(k));
            chk("slot a anode", 16'(anode), 16'(k));
            chk("slot a phase", 16'(phs), 16'h0002);
            ph(1'b0, 1'b0, 1'b1);
            settle();
            chk("slot b cathode", 16'(cath), {14'h0000, ~k});
            chk("slot b anode", 16'(anode), {14'h0000, ~k});
            chk("slot b phase", 16'(phs), 16'h0003);
            ph(1'b0, 1'b1, 1'b1);
            settle();
            chk("both slots cathode", 16'(cath), 16'(k));
            ph(1'b1, 1'b0, 1'b0);
            settle();
            chk("sleep cathode", 16'(cath), 16'(slp_exp[k + 2'h1]));
            chk("sleep anode held", 16'(anode), 16'(k));
            chk("sleep phase", 16'(phs), 16'h0001);
        end
        pdbt_host_model_inst.wr(8'h54, pdbt_host_model_inst.cath_word(1'b1, 2'h1, 2'h0, 2'h0));
        ph(1'b0, 1'b0, 1'b0);
        settle();
        chk("idle cathode", 16'(cath), 16'h0004);
        chk("idle phase", 16'(phs), 16'h0000);
        $display("test cathode override done");
        pdbt_host_model_inst.wr_rd(8'h55, 16'h0db0, rv, ok);
        chk("back to back valid", 16'(ok), 16'h0001);
        chk("gain readback", rv, 16'h0db0);
        pdbt_host_model_inst.wr(8'h56, 16'hffff);
        rdchk("gain after stray write", 8'h55, 16'h0db0);
        for (int e = 0; e < 4; e++) begin
            en_a = e[0];
            en_b = e[1];
            settle();
            chk("b ch4 gain", 16'(g_b4), e[1] ? 16'h0003 : 16'h0000);
            chk("b ch3 gain", 16'(g_b3), e[1] ? 16'h0001 : 16'h0000);
            chk("b ch2 gain", 16'(g_b2), e[1] ? 16'h0002 : 16'h0000);
            chk("a ch4 gain", 16'(g_a4), e[0] ? 16'h0003 : 16'h0000);
            chk("b lanes active", 16'({act_b4, act_b3, act_b2}), e[1] ? 16'h0007 : 16'h0000);
            chk("a lane active", 16'(act_a4), 16'(e[0]));
        end
        $display("test gain lanes done");
        print_verdict();
    end
endmodule : pdbt_bias_gain_tb
`default_nettype wire
